// ==== core/aofd_top.sv ====
// Top of the overrange/fast-detect block with power-down/standby control of the link words.
// Assumes register accesses from the serial control port decoder on the sample clock;
// the power-down/standby pin is asynchronous and is synchronised here.
`timescale 1ns/10ps
module aofd_top
  import aofd_pkg::*;
#(
  parameter int PIPE_LAT = PIPE_LAT_DEF
) (
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              powerdown_standby_pin,
  input  wire logic [14:0]       reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  input  wire logic [ADC_W-1:0]  adc_sample_a,
  input  wire logic [ADC_W-1:0]  adc_sample_b,
  input  wire logic              adc_ovr_a,
  input  wire logic              adc_ovr_b,
  input  wire logic [NUM_VC-1:0] vc_ovr,
  input  wire logic              link_resync,
  output logic      [15:0]       tx_word_a,
  output logic      [15:0]       tx_word_b,
  output logic                   tx_is_k,
  output logic                   link_active,
  output logic                   link_sync_lost,
  output logic                   full_powerdown,
  output logic                   threshold_flag_chan_a,
  output logic                   threshold_flag_chan_b
);

  // The channel pipes need two stages; a pipe as long as the detect limit is refused at elaboration.
  if (PIPE_LAT < 2 || PIPE_LAT >= FD_UP_MAX_CYC) begin : g_lat_chk
    $error("PIPE_LAT out of range");
  end

  typedef struct packed {
    logic [1:0]  pin_sync;
    logic [7:0]  full_powerdown_ctrl;
    logic [7:0]  pin_cfg;
    logic [7:0]  uth_lo;
    logic [7:0]  uth_hi;
    logic [7:0]  lth_lo;
    logic [7:0]  lth_hi;
    logic [7:0]  dwell_lo;
    logic [7:0]  dwell_hi;
    logic [7:0]  ovr_clr;
    logic [7:0]  link_ctrl;
    logic [7:0]  rdata;
    logic        rvalid;
    aofd_mode_t  mode;
    logic        sync_lost;
    logic [15:0] word_a;
    logic [15:0] word_b;
    logic        is_k;
    logic        active;
    logic        pdown;
  } aofd_top_t;

  aofd_top_t st_reg;
  aofd_top_t st_next;

  logic [ADC_W-1:0]  smp_a;
  logic [ADC_W-1:0]  smp_b;
  logic              ovr_a;
  logic              ovr_b;
  logic              flag_a;
  logic              flag_b;
  logic [NUM_VC-1:0] sticky;
  logic [12:0]       upper_thr;
  logic [12:0]       lower_thr;
  logic [15:0]       dwell;
  logic [1:0]        control_bits_per_sample;
  aofd_mode_t        mode_req;

  // Threshold and dwell values are assembled from their byte pairs; unused high bits are ignored.
  assign upper_thr = {st_reg.uth_hi[THR_HI_BITS-1:0], st_reg.uth_lo};
  assign lower_thr = {st_reg.lth_hi[THR_HI_BITS-1:0], st_reg.lth_lo};
  assign dwell     = {st_reg.dwell_hi, st_reg.dwell_lo};
  assign control_bits_per_sample       = st_reg.link_ctrl[CSB_LSB +: 2];

  // Two independent channels, each with its own flag and dwell counter.
  aofd_fd_chan #(.PIPE_LAT(PIPE_LAT)) u_chan_a (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .sample_in      (adc_sample_a),
    .ovr_in         (adc_ovr_a),
    .upper_thr      (upper_thr),
    .lower_thr      (lower_thr),
    .dwell          (dwell),
    .sample_out     (smp_a),
    .ovr_out        (ovr_a),
    .threshold_flag (flag_a)
  );

  aofd_fd_chan #(.PIPE_LAT(PIPE_LAT)) u_chan_b (
    .sys_clk        (sys_clk),
    .sys_rst        (sys_rst),
    .sample_in      (adc_sample_b),
    .ovr_in         (adc_ovr_b),
    .upper_thr      (upper_thr),
    .lower_thr      (lower_thr),
    .dwell          (dwell),
    .sample_out     (smp_b),
    .ovr_out        (ovr_b),
    .threshold_flag (flag_b)
  );

  // The clear register feeds the sticky block directly, so a write sequence acts on the following edges.
  aofd_sticky u_sticky (
    .sys_clk  (sys_clk),
    .sys_rst  (sys_rst),
    .vc_ovr   (vc_ovr),
    .clr_bits (st_reg.ovr_clr),
    .sticky   (sticky)
  );

  assign threshold_flag_chan_a = flag_a;
  assign threshold_flag_chan_b = flag_b;

  // Pack a sample into a link word; bit 1 carries overrange only when control bits exist.
  // Word bit 0 is reserved and always sent as zero.
  function automatic logic [15:0] pack_word(input logic [ADC_W-1:0] s, input logic o, input logic [1:0] c);
    pack_word = {s, (c != 2'h0) ? o : 1'b0, 1'b0};
  endfunction

  // Requested mode: power-down wins over standby, pin and register are ORed.
  // A pin held in power-down overrides the power-down control register; software can only wake it by setting the pin function bit for standby.
  always_comb begin
    mode_req = AOFD_RUN;
    if (st_reg.full_powerdown_ctrl[FULL_POWERDOWN_MODE_LSB +: 2] == PDM_STANDBY) begin
      mode_req = AOFD_STANDBY;
    end
    if (st_reg.pin_sync[1] && st_reg.pin_cfg[PIN_FUNC_BIT]) begin
      mode_req = AOFD_STANDBY;
    end
    if (st_reg.full_powerdown_ctrl[FULL_POWERDOWN_MODE_LSB +: 2] > PDM_STANDBY) begin
      mode_req = AOFD_DOWN;
    end
    if (st_reg.pin_sync[1] && !st_reg.pin_cfg[PIN_FUNC_BIT]) begin
      mode_req = AOFD_DOWN;
    end
  end

  // Register file, read port, mode tracking and link word generation.
  always_comb begin
    st_next          = st_reg;
    // Two flops on the asynchronous pin; only the second one is read by the mode logic.
    st_next.pin_sync = {st_reg.pin_sync[0], powerdown_standby_pin};
    st_next.rvalid   = reg_rd;
    st_next.rdata    = 8'h00;
    // Writes to the status offset and to unmapped offsets fall through and are ignored.
    if (reg_wr) begin
      if (reg_addr == OFS_FULL_POWERDOWN_CTRL) begin
        st_next.full_powerdown_ctrl = reg_wdata;
      end else if (reg_addr == OFS_PIN_CFG) begin
        st_next.pin_cfg = reg_wdata;
      end else if (reg_addr == OFS_UTH_LO) begin
        st_next.uth_lo = reg_wdata;
      end else if (reg_addr == OFS_UTH_HI) begin
        st_next.uth_hi = reg_wdata;
      end else if (reg_addr == OFS_LTH_LO) begin
        st_next.lth_lo = reg_wdata;
      end else if (reg_addr == OFS_LTH_HI) begin
        st_next.lth_hi = reg_wdata;
      end else if (reg_addr == OFS_DWELL_LO) begin
        st_next.dwell_lo = reg_wdata;
      end else if (reg_addr == OFS_DWELL_HI) begin
        st_next.dwell_hi = reg_wdata;
      end else if (reg_addr == OFS_OVR_CLEAR) begin
        st_next.ovr_clr = reg_wdata;
      end else if (reg_addr == OFS_LINK_CTRL) begin
        st_next.link_ctrl = reg_wdata;
      end
    end
    // Reads return the value before a write in the same cycle; unmapped offsets read zero.
    if (reg_rd) begin
      if (reg_addr == OFS_FULL_POWERDOWN_CTRL) begin
        st_next.rdata = st_reg.full_powerdown_ctrl;
      end else if (reg_addr == OFS_PIN_CFG) begin
        st_next.rdata = st_reg.pin_cfg;
      end else if (reg_addr == OFS_UTH_LO) begin
        st_next.rdata = st_reg.uth_lo;
      end else if (reg_addr == OFS_UTH_HI) begin
        st_next.rdata = st_reg.uth_hi;
      end else if (reg_addr == OFS_LTH_LO) begin
        st_next.rdata = st_reg.lth_lo;
      end else if (reg_addr == OFS_LTH_HI) begin
        st_next.rdata = st_reg.lth_hi;
      end else if (reg_addr == OFS_DWELL_LO) begin
        st_next.rdata = st_reg.dwell_lo;
      end else if (reg_addr == OFS_DWELL_HI) begin
        st_next.rdata = st_reg.dwell_hi;
      end else if (reg_addr == OFS_OVR_CLEAR) begin
        st_next.rdata = st_reg.ovr_clr;
      end else if (reg_addr == OFS_OVR_STICKY) begin
        st_next.rdata = sticky;
      end else if (reg_addr == OFS_LINK_CTRL) begin
        st_next.rdata = st_reg.link_ctrl;
      end
    end
    st_next.mode = mode_req;
    // Status outputs are registered here so that every top output leaves a flip-flop.
    st_next.active = mode_req != AOFD_DOWN;
    st_next.pdown  = mode_req == AOFD_DOWN;
    if (link_resync) begin
      st_next.sync_lost = 1'b0;
    end
    case (mode_req)
      AOFD_DOWN: begin
        // The link is stopped outright; the receiver has to resynchronise afterwards.
        st_next.sync_lost = 1'b1;
        st_next.word_a    = ZERO_WORD;
        st_next.word_b    = ZERO_WORD;
        st_next.is_k      = 1'b0;
      end
      AOFD_STANDBY: begin
        // Standby keeps the link alive so the receiver stays locked; only the payload is replaced.
        st_next.is_k = st_reg.link_ctrl[FILL_K_BIT];
        if (st_reg.link_ctrl[FILL_K_BIT]) begin
          st_next.word_a = K_FILL_WORD;
          st_next.word_b = K_FILL_WORD;
        end else begin
          st_next.word_a = ZERO_WORD;
          st_next.word_b = ZERO_WORD;
        end
      end
      default: begin
        st_next.word_a = pack_word(smp_a, ovr_a, control_bits_per_sample);
        st_next.word_b = pack_word(smp_b, ovr_b, control_bits_per_sample);
        st_next.is_k   = 1'b0;
      end
    endcase
  end

  // State register; the upper threshold bytes reset to full scale, the lower threshold to zero and the dwell to one cycle.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg          <= '0;
      st_reg.mode     <= AOFD_RUN;
      st_reg.active   <= 1'b1;
      st_reg.uth_lo   <= RST_UTH_LO;
      st_reg.uth_hi   <= RST_UTH_HI;
      st_reg.lth_lo   <= RST_BYTE;
      st_reg.dwell_lo <= RST_DWELL_LO;
    end else begin
      st_reg <= st_next;
    end
  end

  // Every output is a register field; no logic sits between the flops and the pins.
  assign reg_rdata      = st_reg.rdata;
  assign reg_rvalid     = st_reg.rvalid;
  assign tx_word_a      = st_reg.word_a;
  assign tx_word_b      = st_reg.word_b;
  assign tx_is_k        = st_reg.is_k;
  assign link_active    = st_reg.active;
  assign link_sync_lost = st_reg.sync_lost;
  assign full_powerdown = st_reg.pdown;

  // Mode, link and sticky read checks; registered outputs follow their cause by one edge.
  pin_down_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_reg.pin_sync[1] && !st_reg.pin_cfg[PIN_FUNC_BIT] |=> full_powerdown && !link_active)
    else $error("pin did not power down");
  down_sync_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    full_powerdown |-> link_sync_lost) else $error("sync kept in power-down");
  reg_down_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_reg.full_powerdown_ctrl[1:0] > PDM_STANDBY |=> full_powerdown) else $error("register power-down ignored");
  stby_zero_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_reg.mode == AOFD_STANDBY && !st_reg.link_ctrl[FILL_K_BIT] |-> ##0 1'b1 ##1
    (st_reg.mode != AOFD_STANDBY || $past(st_reg.link_ctrl[FILL_K_BIT]) ||
     (tx_word_a == ZERO_WORD && tx_word_b == ZERO_WORD && link_active)))
    else $error("standby words not zero");
  stby_k_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_req == AOFD_STANDBY && st_reg.link_ctrl[FILL_K_BIT] |=> tx_is_k && tx_word_a == K_FILL_WORD)
    else $error("standby K fill missing");
  csb_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_req == AOFD_RUN && control_bits_per_sample == 2'h0 |=> tx_word_a[1] == 1'b0) else $error("control bit without csb");
  rd_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reg_rd && reg_addr == OFS_OVR_STICKY |=> reg_rvalid && reg_rdata == $past(sticky))
    else $error("sticky read wrong");
  // Further mode, link status and link word checks in standby, power-down and normal running.
  pin_stby_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    st_reg.pin_sync[1] && st_reg.pin_cfg[PIN_FUNC_BIT] && st_reg.full_powerdown_ctrl[1:0] <= PDM_STANDBY
    |=> link_active && st_reg.mode == AOFD_STANDBY) else $error("pin did not select standby");
  stby_link_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_req == AOFD_STANDBY |=> link_active && !full_powerdown) else $error("standby stopped link");
  down_words_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    full_powerdown |-> tx_word_a == ZERO_WORD && tx_word_b == ZERO_WORD && !tx_is_k)
    else $error("words sent in power-down");
  resync_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    link_resync && mode_req != AOFD_DOWN |=> !link_sync_lost) else $error("resync ignored");
  stby_no_k_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_req == AOFD_STANDBY && !st_reg.link_ctrl[FILL_K_BIT] |=> !tx_is_k) else $error("K fill unasked");
  run_data_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_req == AOFD_RUN |=> tx_word_a[15:2] == $past(smp_a) && tx_word_b[15:2] == $past(smp_b))
    else $error("sample word wrong");
  ovr_bit_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    mode_req == AOFD_RUN && control_bits_per_sample != 2'h0 |=> tx_word_a[1] == $past(ovr_a)) else $error("control bit wrong");
  stby_c: cover property (@(posedge sys_clk) disable iff (sys_rst) st_reg.mode == AOFD_STANDBY);
  down_c: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(full_powerdown));

endmodule

// ==== core/aofd_pkg.sv ====
// Package for the converter overrange, fast-detect and power-down/standby link logic.
// Assumes one sample clock and register writes that arrive through the serial control port.
package aofd_pkg;

  // Register offsets on the serial control port.
  localparam logic [14:0] OFS_FULL_POWERDOWN_CTRL  = 15'h003F;
  localparam logic [14:0] OFS_PIN_CFG    = 15'h0040;
  localparam logic [14:0] OFS_UTH_LO     = 15'h0247;
  localparam logic [14:0] OFS_UTH_HI     = 15'h0248;
  localparam logic [14:0] OFS_LTH_LO     = 15'h0249;
  localparam logic [14:0] OFS_LTH_HI     = 15'h024A;
  localparam logic [14:0] OFS_DWELL_LO   = 15'h024B;
  localparam logic [14:0] OFS_DWELL_HI   = 15'h024C;
  localparam logic [14:0] OFS_OVR_CLEAR  = 15'h0562;
  localparam logic [14:0] OFS_OVR_STICKY = 15'h0563;
  localparam logic [14:0] OFS_LINK_CTRL  = 15'h0571;

  // Reset values.
  localparam logic [7:0]  RST_BYTE       = 8'h00;
  localparam logic [7:0]  RST_UTH_HI     = 8'h1F;
  localparam logic [7:0]  RST_UTH_LO     = 8'hFF;
  localparam logic [7:0]  RST_DWELL_LO   = 8'h01;

  // Field positions.
  localparam int          PIN_FUNC_BIT   = 0;
  localparam int          FILL_K_BIT     = 7;
  localparam int          FULL_POWERDOWN_MODE_LSB  = 0;
  localparam int          CSB_LSB        = 0;
  localparam int          THR_HI_BITS    = 5;

  // Power-down control field encodings.
  localparam logic [1:0]  PDM_NORMAL     = 2'h0;
  localparam logic [1:0]  PDM_STANDBY    = 2'h1;

  // Data path widths and link fill.
  localparam int          ADC_W          = 14;
  localparam int          MAG_W          = 14;
  localparam int          NUM_VC         = 8;
  localparam logic [15:0] K_FILL_WORD    = 16'hBCBC;
  localparam logic [15:0] ZERO_WORD      = 16'h0000;

  // Timing: upper threshold detection must finish within this many sample clocks.
  localparam int          FD_UP_MAX_CYC  = 28;
  localparam int          PIPE_LAT_DEF   = 8;

  typedef enum logic [1:0] {AOFD_RUN, AOFD_STANDBY, AOFD_DOWN} aofd_mode_t;

  // Magnitude of a two's complement sample; -2^13 gives exactly full scale 2^13.
  function automatic logic [MAG_W-1:0] aofd_mag(input logic [ADC_W-1:0] s);
    logic [ADC_W-1:0] n;
    n = ~s + {{(ADC_W-1){1'b0}}, 1'b1};
    aofd_mag = s[ADC_W-1] ? n : s;
  endfunction

endpackage

// ==== core/aofd_fd_chan.sv ====
// One converter channel: sample/overrange latency pipe and the fast-detect flag.
// Assumes samples arrive every sample clock from logic in the same clock domain.
`timescale 1ns/10ps
module aofd_fd_chan
  import aofd_pkg::*;
#(
  parameter int PIPE_LAT = PIPE_LAT_DEF
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic [ADC_W-1:0] sample_in,
  input  wire logic             ovr_in,
  input  wire logic [12:0]      upper_thr,
  input  wire logic [12:0]      lower_thr,
  input  wire logic [15:0]      dwell,
  output logic      [ADC_W-1:0] sample_out,
  output logic                  ovr_out,
  output logic                  threshold_flag
);

  // The shift register needs two stages at least, so shorter pipes are refused at elaboration.
  if (PIPE_LAT < 2 || PIPE_LAT > 64) begin : g_lat_chk
    $error("PIPE_LAT out of range");
  end

  typedef struct packed {
    logic [PIPE_LAT-1:0][ADC_W-1:0] smp;
    logic [PIPE_LAT-1:0]            ovr;
    logic                           flag;
    logic [16:0]                    cnt;
  } aofd_fd_t;

  aofd_fd_t st_reg;
  aofd_fd_t st_next;
  logic [MAG_W-1:0] mag_early;
  logic [MAG_W-1:0] mag_late;
  logic             above_upper;
  logic             below_lower;
  logic [16:0]      dwell_eff;

  // Upper compare taps the converter output; lower compare taps the delayed sample.
  assign mag_early   = aofd_mag(sample_in);
  assign mag_late    = aofd_mag(st_reg.smp[PIPE_LAT-1]);
  assign above_upper = mag_early > {1'b0, upper_thr};
  assign below_lower = mag_late < {1'b0, lower_thr};
  assign dwell_eff   = (dwell == 16'h0000) ? 17'h0_0001 : {1'b0, dwell};

  // The flag sets the cycle after a crossing; clearing needs dwell+1 consecutive low samples, two for a dwell of zero.
  always_comb begin
    st_next     = st_reg;
    st_next.smp = {st_reg.smp[PIPE_LAT-2:0], sample_in};
    st_next.ovr = {st_reg.ovr[PIPE_LAT-2:0], ovr_in};
    if (above_upper) begin
      st_next.flag = 1'b1;
      st_next.cnt  = 17'h0_0000;
    end else if (!below_lower) begin
      st_next.cnt = 17'h0_0000;
    end else if (st_reg.flag) begin
      if (st_reg.cnt + 17'h0_0001 > dwell_eff) begin
        st_next.flag = 1'b0;
        st_next.cnt  = 17'h0_0000;
      end else begin
        st_next.cnt = st_reg.cnt + 17'h0_0001;
      end
    end else begin
      st_next.cnt = 17'h0_0000;
    end
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sample_out     = st_reg.smp[PIPE_LAT-1];
  assign ovr_out        = st_reg.ovr[PIPE_LAT-1];
  assign threshold_flag = st_reg.flag;

  fd_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    above_upper |=> threshold_flag) else $error("flag not set after crossing");
  fd_clr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(threshold_flag) |-> $past(below_lower) && !$past(above_upper))
    else $error("flag cleared while not below lower");
  fd_dwell_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(threshold_flag) |-> $past(st_reg.cnt) + 17'h0_0001 > $past(dwell_eff))
    else $error("flag cleared before dwell elapsed");
  fd_restart_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !below_lower |=> st_reg.cnt == 17'h0_0000) else $error("dwell count not restarted");
  ovr_lat_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ##PIPE_LAT (ovr_out == $past(ovr_in, PIPE_LAT))) else $error("overrange latency wrong");
  fd_set_c: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(threshold_flag));
  fd_clr_c: cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(threshold_flag));

endmodule

// ==== core/aofd_sticky.sv ====
// Sticky overrange status, one bit per virtual converter, cleared by a set-then-reset clear bit.
// Assumes overrange events and the clear register come from the same sample clock.
`timescale 1ns/10ps
module aofd_sticky
  import aofd_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic [NUM_VC-1:0] vc_ovr,
  input  wire logic [NUM_VC-1:0] clr_bits,
  output logic      [NUM_VC-1:0] sticky
);

  typedef struct packed {
    logic [NUM_VC-1:0] clr_prev;
    logic [NUM_VC-1:0] stat;
  } aofd_sticky_t;

  aofd_sticky_t st_reg;
  aofd_sticky_t st_next;
  logic [NUM_VC-1:0] clr_fall;

  // Only the return of a clear bit to zero clears; a new event in that cycle still wins.
  assign clr_fall = st_reg.clr_prev & ~clr_bits;

  always_comb begin
    st_next          = st_reg;
    st_next.clr_prev = clr_bits;
    st_next.stat     = (st_reg.stat & ~clr_fall) | vc_ovr;
  end

  // State register.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sticky = st_reg.stat;

  stk_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    |vc_ovr |=> (sticky & $past(vc_ovr)) == $past(vc_ovr)) else $error("overrange not latched");
  stk_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (~sticky & $past(sticky) & ~$past(clr_fall)) == '0) else $error("sticky bit lost without clear");
  stk_clr_c: cover property (@(posedge sys_clk) disable iff (sys_rst) |(~sticky & $past(sticky)));

endmodule

// ==== verification/aofd_link_partner.sv ====
// Far-side model: the link receiver that regains lock after a power-down.
// Assumes it shares sys_clk with the block and sees its link status outputs.
`timescale 1ns/10ps
module aofd_link_partner #(
  parameter int RESYNC_DLY = 4
) (
  input  wire logic sys_clk,
  input  wire logic link_active,
  input  wire logic link_sync_lost,
  output logic      link_resync
);
  int unsigned cnt = 0;
  // Lock is only regained once the link runs again, so a stuck power-down shows as a resync timeout.
  always @(posedge sys_clk) begin
    link_resync <= 1'b0;
    if (link_active && link_sync_lost && !link_resync) begin
      cnt <= cnt + 1;
      if (cnt == RESYNC_DLY) begin
        link_resync <= 1'b1;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule

// ==== verification/aofd_top_tb_top.sv ====
// Self-checking bench for the overrange, fast-detect and standby link logic.
// Assumes the link partner model and a pipeline shortened to two stages.
`timescale 1ns/10ps
module aofd_top_tb_top
  import aofd_pkg::*;
;
  localparam int LAT = 2;
  typedef struct packed {logic [14:0] a; logic [7:0] d;} aofd_row_t;
  logic             sys_clk, sys_rst, powerdown_standby_pin, reg_wr, reg_rd, reg_rvalid;
  logic             adc_ovr_a, adc_ovr_b, link_resync, tx_is_k, link_active, link_sync_lost;
  logic             full_powerdown, threshold_flag_chan_a, threshold_flag_chan_b;
  logic [14:0]      reg_addr;
  logic [7:0]       reg_wdata, reg_rdata, vc_ovr, d;
  logic [13:0]      adc_sample_a, adc_sample_b, s;
  logic [13:0]      h [$];
  logic [15:0]      tx_word_a, tx_word_b;
  int               error_cnt = 0;
  int               num_checks = 0;
  aofd_row_t        rows [12] = '{'{OFS_FULL_POWERDOWN_CTRL, RST_BYTE}, '{OFS_PIN_CFG, RST_BYTE},
    '{OFS_UTH_LO, RST_UTH_LO}, '{OFS_UTH_HI, RST_UTH_HI}, '{OFS_LTH_LO, RST_BYTE},
    '{OFS_LTH_HI, RST_BYTE}, '{OFS_DWELL_LO, RST_DWELL_LO}, '{OFS_DWELL_HI, RST_BYTE},
    '{OFS_OVR_CLEAR, RST_BYTE}, '{OFS_OVR_STICKY, RST_BYTE}, '{OFS_LINK_CTRL, RST_BYTE},
    '{15'h0100, RST_BYTE}};

  aofd_top #(.PIPE_LAT(LAT)) aofd_top_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .powerdown_standby_pin(powerdown_standby_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .adc_sample_a(adc_sample_a), .adc_sample_b(adc_sample_b), .adc_ovr_a(adc_ovr_a),
    .adc_ovr_b(adc_ovr_b), .vc_ovr(vc_ovr), .link_resync(link_resync), .tx_word_a(tx_word_a),
    .tx_word_b(tx_word_b), .tx_is_k(tx_is_k), .link_active(link_active),
    .link_sync_lost(link_sync_lost), .full_powerdown(full_powerdown),
    .threshold_flag_chan_a(threshold_flag_chan_a), .threshold_flag_chan_b(threshold_flag_chan_b));
  aofd_link_partner aofd_link_partner_i (.sys_clk(sys_clk), .link_active(link_active),
    .link_sync_lost(link_sync_lost), .link_resync(link_resync));

  // Sample clock at 50 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s saw %h want %h", $time, msg, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic give_up(input string msg);
    error_cnt++;
    $display("CHECK FAILED at %0t: %s timed out", $time, msg);
    wrap_up();
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Strobes are raised at one falling edge and dropped at the next, so each covers one rising edge.
  task automatic reg_write(input logic [14:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  task automatic reg_read(input logic [14:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    check(reg_rvalid, 1'b1, "read valid");
    v = reg_rdata;
  endtask

  task automatic wait_sync();
    for (int i = 0; i < 40 && link_sync_lost !== 1'b0; i++) @(negedge sys_clk);
    if (link_sync_lost !== 1'b0) give_up("resync");
  endtask

  // Main sequence: reset table first, then the hand-written cases.
  initial begin
    {sys_rst, powerdown_standby_pin, reg_wr, reg_rd, adc_ovr_a, adc_ovr_b} = 6'h20;
    {reg_addr, reg_wdata, vc_ovr, adc_sample_a, adc_sample_b} = '0;
    idle(20);
    sys_rst = 1'b0;
    check({link_active, link_sync_lost, full_powerdown, threshold_flag_chan_a}, 4'h8, "rst");
    foreach (rows[i]) begin
      reg_read(rows[i].a, d);
      check(d, rows[i].d, "reset value");
    end
    $display("test reset done");
    // Distinct samples show that data and the overrange bit share one latency.
    reg_write(OFS_LINK_CTRL, 8'h01);
    for (int i = 0; i < 12; i++) begin
      @(negedge sys_clk);
      if (i > LAT) check(tx_word_a, {h[i-LAT-1], h[i-LAT-1][0], 1'b0}, "word a");
      if (i > LAT) check(tx_word_b, {~h[i-LAT-1], 2'b00}, "word b");
      s = 14'(14'h1000 + i * 37);
      h.push_back(s);
      {adc_sample_a, adc_ovr_a, adc_sample_b} = {s, s[0], ~s};
    end
    $display("test latency done");
    reg_write(OFS_FULL_POWERDOWN_CTRL, {6'h00, PDM_STANDBY});
    idle(2);
    check({link_active, tx_is_k, tx_word_a}, {2'b10, ZERO_WORD}, "zero fill");
    reg_write(OFS_LINK_CTRL, 8'h80);
    idle(2);
    check({tx_is_k, tx_word_b}, {1'b1, K_FILL_WORD}, "k fill");
    reg_write(OFS_FULL_POWERDOWN_CTRL, 8'h02);
    idle(2);
    check({full_powerdown, link_active, link_sync_lost, tx_word_a}, 19'h50000, "full_powerdown reg");
    reg_write(OFS_FULL_POWERDOWN_CTRL, 8'h00);
    wait_sync();
    powerdown_standby_pin = 1'b1;
    idle(4);
    check({full_powerdown, link_active}, 2'b10, "pin default");
    powerdown_standby_pin = 1'b0;
    wait_sync();
    reg_write(OFS_PIN_CFG, 8'h01);
    powerdown_standby_pin = 1'b1;
    idle(4);
    check({full_powerdown, link_active, tx_is_k}, 3'b011, "pin standby");
    powerdown_standby_pin = 1'b0;
    $display("test modes done");
    vc_ovr = 8'hA5;
    idle(1);
    vc_ovr = 8'h00;
    reg_write(OFS_OVR_STICKY, 8'h00);
    reg_read(OFS_OVR_STICKY, d);
    check(d, 8'hA5, "sticky set");
    reg_write(OFS_OVR_CLEAR, 8'h05);
    idle(2);
    reg_read(OFS_OVR_STICKY, d);
    check(d, 8'hA5, "clear half");
    reg_write(OFS_OVR_CLEAR, 8'h00);
    idle(2);
    reg_read(OFS_OVR_STICKY, d);
    check(d, 8'hA0, "cleared");
    $display("test sticky done");
    // Upper 0x100, lower 0x80, dwell 3; samples sit at the upper level first so no write sets a flag.
    {adc_sample_a, adc_sample_b} = {14'h0100, 14'h3F00};
    foreach (rows[i]) if (i >= 2 && i <= 7) reg_write(rows[i].a, 8'((48'h0003_0080_0100 >> (8 * (i - 2)))));
    idle(4);
    check({threshold_flag_chan_a, threshold_flag_chan_b}, 2'b00, "equal upper");
    adc_sample_a = 14'h3EFF;
    for (int i = 0; i < FD_UP_MAX_CYC && threshold_flag_chan_a !== 1'b1; i++) idle(1);
    check({threshold_flag_chan_a, threshold_flag_chan_b}, 2'b10, "flag set");
    for (int i = 0; i < 8; i++) begin
      adc_sample_a = (i == 3) ? 14'h0080 : 14'h0040;
      idle(1);
    end
    check(threshold_flag_chan_a, 1'b1, "dwell restart");
    for (int i = 0; i < 40 && threshold_flag_chan_a !== 1'b0; i++) idle(1);
    if (threshold_flag_chan_a !== 1'b0) give_up("flag clear");
    check(threshold_flag_chan_b, 1'b0, "chan b quiet");
    $display("test fast detect done");
    wrap_up();
  end
endmodule
